//--- hdl/tbd_pkg.sv
package tbd_pkg;
    // Instruction classes decoded by this block
    typedef enum logic [5:0] {
        TBD_OP_NONE,       TBD_OP_NOP,        TBD_OP_MOV_A,
        TBD_OP_MOV_REG,    TBD_OP_MOV_DIR,    TBD_OP_MOV_IND,
        TBD_OP_MOV_DATA_POINTER_16,   TBD_OP_CODE_READ,  TBD_OP_XDATA_RD,
        TBD_OP_XDATA_WR,   TBD_OP_PUSH,       TBD_OP_POP,
        TBD_OP_BYTE_XCHG,  TBD_OP_NIB_XCHG,   TBD_OP_CARRY_LOGIC,
        TBD_OP_BIT_MOVE,   TBD_OP_BIT_SET,    TBD_OP_ABS_CALL,
        TBD_OP_ABS_JUMP,   TBD_OP_LONG_CALL,  TBD_OP_LONG_JUMP,
        TBD_OP_RETURN,     TBD_OP_INT_RETURN, TBD_OP_REL_JUMP,
        TBD_OP_BIT_JUMP,   TBD_OP_ACC_JUMP,   TBD_OP_IND_JUMP,
        TBD_OP_CMP_JUMP,   TBD_OP_DEC_JUMP
    } tbd_class_t;

    // Operand sources and destinations
    typedef enum logic [2:0] {
        TBD_SRC_NONE, TBD_SRC_ACC, TBD_SRC_REG, TBD_SRC_DIR,
        TBD_SRC_IND,  TBD_SRC_IMM, TBD_SRC_DATA_POINTER_16, TBD_SRC_PC
    } tbd_src_t;

    // Decoded result for one opcode
    typedef struct packed {
        logic       valid;
        tbd_class_t cls;
        logic [1:0] length;
        logic [3:0] cycles;
        tbd_src_t   src;
        tbd_src_t   dst;
        logic [2:0] reg_sel;
        logic       ptr_sel;
        logic       use_reg;
        logic       use_ptr;
        logic       bit_inv;
        logic       cond_sense;
        logic       bit_clear;
    } tbd_dec_t;

    localparam logic [1:0] TBD_LEN_1   = 2'h1;
    localparam logic [1:0] TBD_LEN_2   = 2'h2;
    localparam logic [1:0] TBD_LEN_3   = 2'h3;
    localparam logic [3:0] TBD_CYC_2   = 4'h2;
    localparam logic [3:0] TBD_CYC_4   = 4'h4;
    localparam int         TBD_REG_LSB = 0;
    localparam int         TBD_REG_W   = 3;
    localparam int         TBD_PAGE_LSB = 5;
    localparam logic [4:0] TBD_ABS_JMP_LOW  = 5'h01;
    localparam logic [4:0] TBD_ABS_CALL_LOW = 5'h11;
    localparam logic [7:0] TBD_OPC_RESET = 8'h00;
endpackage

//--- hdl/tbd_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
// Opcode in, decoded word out, between core and table
interface tbd_dec_if;
    import tbd_pkg::*;
    logic [7:0] opcode;
    tbd_dec_t   dec;
    modport table_side (input opcode, output dec);
    modport user_side  (output opcode, input dec);
endinterface
`default_nettype wire

//--- hdl/tbd_opcode_table.sv
`timescale 1ns/1ps
`default_nettype none
module tbd_opcode_table (
    tbd_dec_if.table_side dif  // Opcode and decoded word
);
    import tbd_pkg::*;

    // Classify one opcode
    always_comb begin
        logic [7:0] op;
        tbd_dec_t   d;
        op        = dif.opcode;
        d         = '0;
        d.valid   = 1'b1;
        d.cls     = TBD_OP_NONE;
        d.length  = TBD_LEN_1;
        d.cycles  = TBD_CYC_2;
        d.reg_sel = op[TBD_REG_LSB +: TBD_REG_W];
        d.ptr_sel = op[0];
        if (op[4:0] == TBD_ABS_JMP_LOW) begin
            d.cls = TBD_OP_ABS_JUMP; d.length = TBD_LEN_2;
            d.cycles = TBD_CYC_4;
        end else if (op[4:0] == TBD_ABS_CALL_LOW) begin
            d.cls = TBD_OP_ABS_CALL; d.length = TBD_LEN_2;
            d.cycles = TBD_CYC_4;
        end else if (op[3]) begin
            // Bank register groups
            d.use_reg = 1'b1;
            case (op[7:4])
                4'hE: begin d.cls = TBD_OP_MOV_A; d.src = TBD_SRC_REG;
                    d.dst = TBD_SRC_ACC; end
                4'hF: begin d.cls = TBD_OP_MOV_REG; d.src = TBD_SRC_ACC;
                    d.dst = TBD_SRC_REG; end
                4'hA: begin d.cls = TBD_OP_MOV_REG; d.src = TBD_SRC_DIR;
                    d.dst = TBD_SRC_REG; d.length = TBD_LEN_2;
                    d.cycles = TBD_CYC_4; end
                4'h7: begin d.cls = TBD_OP_MOV_REG; d.src = TBD_SRC_IMM;
                    d.dst = TBD_SRC_REG; d.length = TBD_LEN_2; end
                4'h8: begin d.cls = TBD_OP_MOV_DIR; d.src = TBD_SRC_REG;
                    d.dst = TBD_SRC_DIR; d.length = TBD_LEN_2;
                    d.cycles = TBD_CYC_4; end
                4'hC: begin d.cls = TBD_OP_BYTE_XCHG; d.src = TBD_SRC_REG;
                    d.dst = TBD_SRC_ACC; end
                4'hB: begin d.cls = TBD_OP_CMP_JUMP; d.src = TBD_SRC_IMM;
                    d.dst = TBD_SRC_REG; d.length = TBD_LEN_3;
                    d.cycles = TBD_CYC_4; end
                4'hD: begin d.cls = TBD_OP_DEC_JUMP; d.dst = TBD_SRC_REG;
                    d.length = TBD_LEN_2; d.cycles = TBD_CYC_4; end
                default: begin d.valid = 1'b0; d.use_reg = 1'b0; end
            endcase
        end else if (op[3:1] == 3'h3) begin
            // Indirect pointer register groups
            d.use_ptr = 1'b1;
            case (op[7:4])
                4'hE: begin d.cls = TBD_OP_MOV_A; d.src = TBD_SRC_IND;
                    d.dst = TBD_SRC_ACC; end
                4'h8: begin d.cls = TBD_OP_MOV_DIR; d.src = TBD_SRC_IND;
                    d.dst = TBD_SRC_DIR; d.length = TBD_LEN_2;
                    d.cycles = TBD_CYC_4; end
                4'hF: begin d.cls = TBD_OP_MOV_IND; d.src = TBD_SRC_ACC;
                    d.dst = TBD_SRC_IND; end
                4'hA: begin d.cls = TBD_OP_MOV_IND; d.src = TBD_SRC_DIR;
                    d.dst = TBD_SRC_IND; d.length = TBD_LEN_2;
                    d.cycles = TBD_CYC_4; end
                4'h7: begin d.cls = TBD_OP_MOV_IND; d.src = TBD_SRC_IMM;
                    d.dst = TBD_SRC_IND; d.length = TBD_LEN_2; end
                4'hC: begin d.cls = TBD_OP_BYTE_XCHG; d.src = TBD_SRC_IND;
                    d.dst = TBD_SRC_ACC; end
                4'hD: begin d.cls = TBD_OP_NIB_XCHG; d.src = TBD_SRC_IND;
                    d.dst = TBD_SRC_ACC; end
                4'hB: begin d.cls = TBD_OP_CMP_JUMP; d.src = TBD_SRC_IMM;
                    d.dst = TBD_SRC_IND; d.length = TBD_LEN_3;
                    d.cycles = TBD_CYC_4; end
                default: begin d.valid = 1'b0; d.use_ptr = 1'b0; end
            endcase
        end else if (op[3:1] == 3'h1 && op[7:5] == 3'h7) begin
            // External data moves through the pointer register
            d.use_ptr = 1'b1;
            d.cycles  = TBD_CYC_4;
            d.cls = op[4] ? TBD_OP_XDATA_WR : TBD_OP_XDATA_RD;
            d.src = op[4] ? TBD_SRC_ACC : TBD_SRC_IND;
            d.dst = op[4] ? TBD_SRC_IND : TBD_SRC_ACC;
        end else begin
            d.cycles = TBD_CYC_4;
            case (op)
                8'h00: begin d.cls = TBD_OP_NOP; d.cycles = TBD_CYC_2; end
                8'hE5: begin d.cls = TBD_OP_MOV_A; d.src = TBD_SRC_DIR;
                    d.dst = TBD_SRC_ACC; d.length = TBD_LEN_2;
                    d.cycles = TBD_CYC_2; end
                8'h74: begin d.cls = TBD_OP_MOV_A; d.src = TBD_SRC_IMM;
                    d.dst = TBD_SRC_ACC; d.length = TBD_LEN_2;
                    d.cycles = TBD_CYC_2; end
                8'hF5: begin d.cls = TBD_OP_MOV_DIR; d.src = TBD_SRC_ACC;
                    d.dst = TBD_SRC_DIR; d.length = TBD_LEN_2;
                    d.cycles = TBD_CYC_2; end
                8'h85: begin d.cls = TBD_OP_MOV_DIR; d.src = TBD_SRC_DIR;
                    d.dst = TBD_SRC_DIR; d.length = TBD_LEN_3; end
                8'h75: begin d.cls = TBD_OP_MOV_DIR; d.src = TBD_SRC_IMM;
                    d.dst = TBD_SRC_DIR; d.length = TBD_LEN_3; end
                8'h90: begin d.cls = TBD_OP_MOV_DATA_POINTER_16; d.src = TBD_SRC_IMM;
                    d.dst = TBD_SRC_DATA_POINTER_16; d.length = TBD_LEN_3; end
                8'h93: begin d.cls = TBD_OP_CODE_READ; d.src = TBD_SRC_DATA_POINTER_16;
                    d.dst = TBD_SRC_ACC; end
                8'h83: begin d.cls = TBD_OP_CODE_READ; d.src = TBD_SRC_PC;
                    d.dst = TBD_SRC_ACC; end
                8'hE0: begin d.cls = TBD_OP_XDATA_RD; d.src = TBD_SRC_DATA_POINTER_16;
                    d.dst = TBD_SRC_ACC; end
                8'hF0: begin d.cls = TBD_OP_XDATA_WR; d.src = TBD_SRC_ACC;
                    d.dst = TBD_SRC_DATA_POINTER_16; end
                8'hC0: begin d.cls = TBD_OP_PUSH; d.src = TBD_SRC_DIR;
                    d.length = TBD_LEN_2; end
                8'hD0: begin d.cls = TBD_OP_POP; d.dst = TBD_SRC_DIR;
                    d.length = TBD_LEN_2; end
                8'hC5: begin d.cls = TBD_OP_BYTE_XCHG; d.src = TBD_SRC_DIR;
                    d.dst = TBD_SRC_ACC; d.length = TBD_LEN_2;
                    d.cycles = TBD_CYC_2; end
                8'h82, 8'h72: begin d.cls = TBD_OP_CARRY_LOGIC;
                    d.length = TBD_LEN_2; end
                8'hB0, 8'hA0: begin d.cls = TBD_OP_CARRY_LOGIC;
                    d.bit_inv = 1'b1; d.length = TBD_LEN_2; end
                8'hA2: begin d.cls = TBD_OP_BIT_MOVE; d.dst = TBD_SRC_NONE;
                    d.length = TBD_LEN_2; d.cycles = TBD_CYC_2; end
                8'h92: begin d.cls = TBD_OP_BIT_MOVE; d.cond_sense = 1'b1;
                    d.length = TBD_LEN_2; end
                8'hC3, 8'hD3, 8'hB3: begin d.cls = TBD_OP_BIT_SET;
                    d.cycles = TBD_CYC_2; end
                8'hC2, 8'hD2, 8'hB2: begin d.cls = TBD_OP_BIT_SET;
                    d.length = TBD_LEN_2; d.cycles = TBD_CYC_2; end
                8'h12: begin d.cls = TBD_OP_LONG_CALL;
                    d.length = TBD_LEN_3; end
                8'h22: d.cls = TBD_OP_RETURN;
                8'h32: d.cls = TBD_OP_INT_RETURN;
                8'h80: begin d.cls = TBD_OP_REL_JUMP;
                    d.length = TBD_LEN_2; end
                8'h40, 8'h50: begin d.cls = TBD_OP_REL_JUMP;
                    d.cond_sense = ~op[4]; d.length = TBD_LEN_2; end
                8'h20, 8'h30, 8'h10: begin d.cls = TBD_OP_BIT_JUMP;
                    d.cond_sense = (op[5:4] != 2'h3);
                    d.bit_clear = (op[5:4] == 2'h1);
                    d.length = TBD_LEN_3; end
                8'h60, 8'h70: begin d.cls = TBD_OP_ACC_JUMP;
                    d.cond_sense = ~op[4]; d.length = TBD_LEN_2; end
                8'h02: begin d.cls = TBD_OP_LONG_JUMP;
                    d.length = TBD_LEN_3; end
                8'h73: begin d.cls = TBD_OP_IND_JUMP;
                    d.src = TBD_SRC_DATA_POINTER_16; end
                8'hB5: begin d.cls = TBD_OP_CMP_JUMP; d.src = TBD_SRC_DIR;
                    d.dst = TBD_SRC_ACC; d.length = TBD_LEN_3; end
                8'hB4: begin d.cls = TBD_OP_CMP_JUMP; d.src = TBD_SRC_IMM;
                    d.dst = TBD_SRC_ACC; d.length = TBD_LEN_3; end
                8'hD5: begin d.cls = TBD_OP_DEC_JUMP; d.dst = TBD_SRC_DIR;
                    d.length = TBD_LEN_3; end
                default: begin d.valid = 1'b0; d.cycles = TBD_CYC_2; end
            endcase
        end
        dif.dec = d;
    end
endmodule
`default_nettype wire

//--- hdl/tbd_branch_calc.sv
`timescale 1ns/1ps
`default_nettype none
module tbd_branch_calc (
    input  wire logic [15:0] next_pc,   // Address after the branch
    input  wire logic [7:0]  rel,       // Signed relative offset
    input  wire logic [7:0]  opcode,    // Absolute jump opcode
    input  wire logic [7:0]  low_byte,  // Second instruction byte
    input  wire logic [7:0]  cmp_a,     // First compare operand
    input  wire logic [7:0]  cmp_b,     // Second compare operand
    output logic      [15:0] rel_target, // Relative destination
    output logic      [15:0] abs_target, // Absolute destination
    output logic             cmp_ne,     // Operands differ
    output logic             cmp_carry   // First below second
);
    import tbd_pkg::*;

    // Signed offset plus next address
    assign rel_target = next_pc + {{8{rel[7]}}, rel};
    // Page from opcode, low bits from operand
    assign abs_target = {next_pc[15:11],
                         opcode[7:TBD_PAGE_LSB], low_byte};
    // Unsigned compare outcome
    assign cmp_ne    = (cmp_a != cmp_b);
    assign cmp_carry = (cmp_a < cmp_b);
endmodule
`default_nettype wire

//--- hdl/tbd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Bank register number is the lowest three opcode bits.
// - Absolute jump, call: address bits 10-8 from opcode top.
// - Moves into accumulator take 2 cycles.
// - Bank register moves: per-source lengths and cycles.
// - Direct byte moves: 2 cycles from accumulator, else 4.
// - Indirect moves take 2 or 4 cycles by source.
// - Data pointer load is 3 bytes, 4 cycles.
// - Code memory reads are 1 byte, 4 cycles.
// - External data reads are 1 byte, 4 cycles.
// - External data writes are 1 byte, 4 cycles.
// - Push and pop are 2 bytes, 4 cycles.
// - Byte exchanges take 2 cycles.
// - Low nibble exchange is 1 byte, 2 cycles.
// - Carry logic with a bit is 2 bytes, 4 cycles.
// - Bit to carry takes 2 cycles, carry to bit takes 4.
// - Long call, return and interrupt return take 4 cycles.
// - Short and carry relative jumps are 2 bytes, 4 cycles.
// - Bit test jumps are 3 bytes, 4 cycles.
// - Accumulator zero jumps are 2 bytes, 4 cycles.
// - Long jump and indirect jump take 4 cycles.
// - Compare and jump forms are 3 bytes, 4 cycles.
// - Decrement and jump forms take 4 cycles.
module tbd_decoder (
    input  wire logic         clk,          // System clock
    input  wire logic         resetn,       // Sync reset, low
    input  wire logic         op_valid,     // Opcode offered
    input  wire logic [7:0]   opcode,       // First byte
    input  wire logic [7:0]   byte2,        // Second byte
    input  wire logic [7:0]   byte3,        // Third byte
    input  wire logic [15:0]  instr_pc,     // Opcode address
    input  wire logic [7:0]   acc,          // Accumulator value
    input  wire logic [7:0]   operand,      // Compare operand
    output logic              op_ready,     // Decoder idle
    output tbd_pkg::tbd_dec_t dec,          // Held decode word
    output logic [15:0]       next_pc,      // Following address
    output logic [15:0]       target,       // Branch destination
    output logic              cmp_carry,    // Compare carry
    output logic              cmp_ne,       // Compare unequal
    output logic              exec_active,  // Executing
    output logic              exec_last     // Final cycle
);
    import tbd_pkg::*;

    typedef enum {TBD_ST_IDLE, TBD_ST_EXEC} tbd_state_t;

    // Whole module state
    typedef struct packed {
        tbd_state_t  st;
        tbd_dec_t    dec;
        logic [3:0]  cnt;
        logic [15:0] next_pc;
        logic [15:0] target;
        logic        carry;
        logic        ne;
    } tbd_regs_t;

    tbd_regs_t  s_r;
    tbd_regs_t  s_nxt;
    logic [15:0] pc_after;
    logic [15:0] rel_t;
    logic [15:0] abs_t;
    logic        c_ne;
    logic        c_cy;
    logic [7:0]  rel_byte;
    logic [7:0]  cmp_rhs;

    tbd_dec_if dif ();

    assign dif.opcode = opcode;

    tbd_opcode_table u_table (
        .dif (dif.table_side)
    );

    // Following address
    assign pc_after = instr_pc + {14'h0000, dif.dec.length};
    // Relative byte is the last byte
    assign rel_byte = (dif.dec.length == TBD_LEN_3) ? byte3 : byte2;
    // Immediate or direct compare operand
    assign cmp_rhs  = (dif.dec.src == TBD_SRC_IMM) ? byte2 : operand;

    tbd_branch_calc u_calc (
        .next_pc    (pc_after),
        .rel        (rel_byte),
        .opcode     (opcode),
        .low_byte   (byte2),
        .cmp_a      ((dif.dec.dst == TBD_SRC_ACC) ? acc : operand),
        .cmp_b      (cmp_rhs),
        .rel_target (rel_t),
        .abs_target (abs_t),
        .cmp_ne     (c_ne),
        .cmp_carry  (c_cy)
    );

    // Next state
    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            TBD_ST_IDLE: begin
                if (op_valid) begin
                    s_nxt.st      = TBD_ST_EXEC;
                    s_nxt.dec     = dif.dec;
                    s_nxt.cnt     = dif.dec.cycles - 4'h1;
                    s_nxt.next_pc = pc_after;
                    s_nxt.carry   = c_cy;
                    s_nxt.ne      = c_ne;
                    case (dif.dec.cls)
                        TBD_OP_ABS_JUMP,
                        TBD_OP_ABS_CALL: s_nxt.target = abs_t;
                        TBD_OP_LONG_JUMP,
                        TBD_OP_LONG_CALL: s_nxt.target = {byte2, byte3};
                        TBD_OP_REL_JUMP, TBD_OP_BIT_JUMP,
                        TBD_OP_ACC_JUMP, TBD_OP_CMP_JUMP,
                        TBD_OP_DEC_JUMP: s_nxt.target = rel_t;
                        default: s_nxt.target = pc_after;
                    endcase
                end
            end
            TBD_ST_EXEC: begin
                s_nxt.cnt = s_r.cnt - 4'h1;
                if (s_r.cnt == 4'h1) begin
                    s_nxt.st = TBD_ST_IDLE;
                end
            end
            default: s_nxt.st = TBD_ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign op_ready    = (s_r.st == TBD_ST_IDLE);
    assign dec         = s_r.dec;
    assign next_pc     = s_r.next_pc;
    assign target      = s_r.target;
    assign cmp_carry   = s_r.carry;
    assign cmp_ne      = s_r.ne;
    assign exec_active = (s_r.st == TBD_ST_EXEC);
    assign exec_last   = exec_active && (s_r.cnt == 4'h1);
endmodule
`default_nettype wire

//--- sim/tbd_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tbd_decoder_checker (
    input wire logic              clk,         // System clock
    input wire logic              resetn,      // Sync reset, low
    input wire logic              op_valid,    // Opcode offered
    input wire logic [7:0]        opcode,      // First byte
    input wire logic [7:0]        byte2,       // Second byte
    input wire logic [7:0]        byte3,       // Third byte
    input wire logic [15:0]       instr_pc,    // Opcode address
    input wire logic [7:0]        acc,         // Accumulator value
    input wire logic [7:0]        operand,     // Compare operand
    input wire logic              op_ready,    // Decoder idle
    input wire tbd_pkg::tbd_dec_t dec,         // Held decode word
    input wire logic [15:0]       next_pc,     // Following address
    input wire logic [15:0]       target,      // Branch destination
    input wire logic              cmp_carry,   // Compare carry
    input wire logic              cmp_ne,      // Compare unequal
    input wire logic              exec_active, // Executing
    input wire logic              exec_last    // Final cycle
);
    import tbd_pkg::*;
    logic [15:0] rel_ext;
    logic [10:0] abs_low;
    logic [15:0] long_addr;
    // Operand views
    assign rel_ext = {{8{byte2[7]}}, byte2};
    assign abs_low = {opcode[7:5], byte2};
    assign long_addr = {byte2, byte3};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Accept and run shapes
    sequence take_s; op_valid && op_ready; endsequence
    sequence short_run_s; exec_active && exec_last ##1 op_ready; endsequence
    sequence long_run_s;
        (exec_active && !exec_last) [*2] ##1 exec_last ##1 op_ready;
    endsequence
    chk_short_exec: assert property (
        take_s ##1 dec.cycles == TBD_CYC_2 |-> short_run_s)
        else $error("short run wrong");
    chk_long_exec: assert property (
        take_s ##1 dec.cycles == TBD_CYC_4 |-> long_run_s)
        else $error("long run wrong");
    chk_reg_number: assert property (
        take_s ##0 opcode[7:3] == 5'h1D |=>
        dec.use_reg && dec.reg_sel == $past(opcode[2:0]))
        else $error("register wrong");
    chk_abs_dest: assert property (
        take_s ##0 opcode[4:0] == TBD_ABS_JMP_LOW |=>
        target[10:0] == $past(abs_low))
        else $error("abs target wrong");
    chk_rel_dest: assert property (
        take_s ##0 opcode == 8'h80 |=>
        target == $past(instr_pc) + 16'h0002 + $past(rel_ext))
        else $error("rel target wrong");
    chk_cmp_flags: assert property (
        take_s ##0 opcode == 8'hB4 |=>
        cmp_carry == ($past(acc) < $past(byte2)) &&
        cmp_ne == ($past(acc) != $past(byte2)))
        else $error("compare flags wrong");
    chk_long_dest: assert property (
        take_s ##0 opcode == 8'h02 |=>
        target == $past(long_addr) && dec.length == TBD_LEN_3)
        else $error("long target wrong");
    chk_ptr_load: assert property (
        take_s ##0 opcode == 8'h90 |=>
        dec.length == TBD_LEN_3 && dec.cycles == TBD_CYC_4)
        else $error("load shape wrong");
    chk_busy_hold: assert property (
        !op_ready |=> $stable(dec) && $stable(target))
        else $error("busy change");
endmodule
`default_nettype wire

//--- sim/tbd_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module tbd_fetch_model (
    input  wire logic  clk,      // System clock
    input  wire logic  op_ready, // Decoder idle
    output logic       op_valid, // Opcode offered
    output logic [7:0] opcode,   // First byte
    output logic [7:0] byte2,    // Second byte
    output logic [7:0] byte3,    // Third byte
    output logic [7:0] acc,      // Accumulator value
    output logic [7:0] operand,  // Compare operand
    output logic [15:0] instr_pc // Opcode address
);
    // Quiet at start
    initial begin
        {op_valid, opcode, byte2, byte3, acc, operand, instr_pc} = '0;
    end
    // Offer at falling edge until taken
    task automatic issue(input logic [7:0] o, b2, b3, a, r,
                         input logic [15:0] ad, output bit ok);
        int n;
        n = 0;
        @(negedge clk);
        op_valid <= 1'b1;
        opcode <= o;
        byte2 <= b2;
        byte3 <= b3;
        acc <= a;
        operand <= r;
        instr_pc <= ad;
        #1;
        while (op_ready !== 1'b1 && n < 40) begin
            @(negedge clk);
            #1;
            n++;
        end
        ok = (n < 40);
    endtask
    // Released lines show inverse
    task automatic idle();
        @(negedge clk);
        op_valid <= 1'b0;
        {opcode, byte2, byte3, acc, operand, instr_pc} <=
            ~{opcode, byte2, byte3, acc, operand, instr_pc};
    endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import tbd_pkg::*;
    // Expected outcome
    typedef struct {
        logic        vld, rchk, tchk, cchk, cy, ne;
        logic [1:0]  len;
        logic [3:0]  cyc;
        logic [15:0] npc, tgt;
        logic [2:0]  rs;
    } tbd_exp_t;
    // Opcode, mask, length, cycles; length 0 undefined
    localparam logic [19:0] OPS [59] = '{
        20'hE8712, 20'hE5022, 20'hE6112, 20'h74022, 20'hF8712,
        20'hA8724, 20'h78722, 20'hF5022, 20'h88724, 20'h86124,
        20'h85034, 20'h75034, 20'hF6112, 20'hA6124, 20'h76122,
        20'h90034, 20'h93014, 20'h83014, 20'hE2114, 20'hE0014,
        20'hF2114, 20'hF0014, 20'hC0024, 20'hD0024, 20'hC8712,
        20'hC5022, 20'hC6112, 20'hD6112, 20'h82024, 20'hB0024,
        20'h72024, 20'hA0024, 20'hA2022, 20'h92024, 20'h11E24,
        20'h12034, 20'h22014, 20'h32014, 20'h01E24, 20'h02034,
        20'h80024, 20'h40024, 20'h50024, 20'h20034, 20'h30034,
        20'h10034, 20'h73014, 20'h60024, 20'h70024, 20'hB5034,
        20'hB4034, 20'hB8734, 20'hB6134, 20'hD8724, 20'hD5034,
        20'h00012, 20'hC2022, 20'h24002, 20'h53002};
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        op_valid, op_ready, cmp_carry, cmp_ne, exec_active, exec_last;
    logic [7:0]  opcode, byte2, byte3, acc, operand;
    logic [15:0] instr_pc, next_pc, target;
    tbd_dec_t    dec;
    tbd_exp_t    exp_q[$];
    int          miscompares = 0;
    int          samples_checked = 0;
    int          seed = 20026;
    // 50 MHz system clock
    always #10 clk = ~clk;
    tbd_fetch_model fetch_i (.clk, .op_ready, .op_valid, .opcode, .byte2,
        .byte3, .acc, .operand, .instr_pc);
    tbd_decoder tbd_decoder_i (.clk, .resetn, .op_valid, .opcode, .byte2,
        .byte3, .instr_pc, .acc, .operand, .op_ready, .dec, .next_pc,
        .target, .cmp_carry, .cmp_ne, .exec_active, .exec_last);
    // One comparison
    task automatic cmp(input string nm, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Reset mid execution
    task automatic mid_reset();
        @(posedge clk);
        @(negedge clk);
        resetn <= 1'b0;
        fetch_i.idle();
        repeat (2) @(negedge clk);
        #2;
        cmp("ready_in_reset", 16'h0001, 16'(op_ready));
        cmp("idle_in_reset", 16'h0000, 16'({exec_active, exec_last}));
        cmp("dec_in_reset", 16'h0001, 16'(dec === '0));
        resetn <= 1'b1;
    endtask
    // Pair accept with oldest note
    always begin
        tbd_exp_t x;
        int       n;
        @(negedge clk);
        #2;
        if (resetn === 1'b1 && op_valid === 1'b1 && op_ready === 1'b1) begin
            @(negedge clk);
            #2;
            x = exp_q.pop_front();
            cmp("valid", 16'(x.vld), 16'(dec.valid));
            if (x.vld) begin
                cmp("length", 16'(x.len), 16'(dec.length));
                cmp("cycles", 16'(x.cyc), 16'(dec.cycles));
                cmp("next_pc", x.npc, next_pc);
            end
            if (x.rchk) cmp("reg_sel", 16'(x.rs), 16'(dec.reg_sel));
            if (x.tchk) cmp("target", x.tgt, target);
            if (x.cchk) cmp("cmp", 16'({x.cy, x.ne}), 16'({cmp_carry, cmp_ne}));
            n = 1;
            while (exec_last !== 1'b1 && resetn === 1'b1 && n < 20) begin
                @(negedge clk);
                #2;
                n++;
            end
            if (resetn === 1'b1) cmp("exec_len", 16'(x.cyc), 16'(n + 1));
        end
    end
    // Sweep the listed OPS forms, three passes
    initial begin
        logic [19:0] e;
        logic [31:0] r1, r2;
        logic [7:0]  o, fa, sb;
        tbd_exp_t    x;
        bit          ok;
        int          n;
        repeat (20) @(negedge clk);
        resetn <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            foreach (OPS[i]) begin
                e = OPS[i];
                r1 = $random(seed);
                r2 = $random(seed);
                if (r2[20]) r1[31:24] = r1[23:16];
                if (r2[21]) r1[7:0] = r1[31:24];
                o = e[19:12];
                if (e[11:8] == 4'h7) o[2:0] = r2[18:16];
                if (e[11:8] == 4'h1) o[0] = r2[16];
                if (e[11:8] == 4'hE) o[7:5] = r2[18:16];
                x = '{default: '0};
                x.vld = (e[7:4] != 4'h0);
                x.len = e[5:4];
                x.cyc = e[3:0];
                x.npc = r2[15:0] + 16'(e[5:4]);
                x.rchk = (e[11:8] == 4'h7);
                x.rs = o[2:0];
                x.tchk = 1'b1;
                if (e[11:8] == 4'hE) x.tgt = {x.npc[15:11], o[7:5], r1[7:0]};
                else if (o inside {8'h80, 8'h40, 8'h50, 8'h60, 8'h70, [8'hD8:8'hDF]})
                    x.tgt = x.npc + {{8{r1[7]}}, r1[7:0]};
                else if (o inside {8'h20, 8'h30, 8'h10, 8'hD5, [8'hB4:8'hBF]})
                    x.tgt = x.npc + {{8{r1[15]}}, r1[15:8]};
                else if (o inside {8'h02, 8'h12}) x.tgt = {r1[7:0], r1[15:8]};
                else x.tchk = 1'b0;
                fa = (o < 8'hB6) ? r1[23:16] : r1[31:24];
                sb = (o == 8'hB5) ? r1[31:24] : r1[7:0];
                x.cchk = (o inside {[8'hB4:8'hBF]});
                x.cy = (fa < sb);
                x.ne = (fa != sb);
                exp_q.push_back(x);
                fetch_i.issue(o, r1[7:0], r1[15:8], r1[23:16], r1[31:24],
                              r2[15:0], ok);
                if (!ok) begin
                    miscompares++;
                    tally_and_finish();
                end
                if (p == 1 && o == 8'h12) mid_reset();
            end
        end
        fetch_i.idle();
        n = 0;
        while (exp_q.size() != 0 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (n >= 50) miscompares++;
        repeat (6) @(negedge clk);
        tally_and_finish();
    end
endmodule
bind tbd_decoder tbd_decoder_checker tbd_decoder_checker_i (.clk, .resetn,
    .op_valid, .opcode, .byte2, .byte3, .instr_pc, .acc, .operand, .op_ready,
    .dec, .next_pc, .target, .cmp_carry, .cmp_ne, .exec_active, .exec_last);
`default_nettype wire
